// ===== verilog/dssw_defines.svh
// constants for the drive state status word block
`ifndef DSSW_DEFINES_SVH
`define DSSW_DEFINES_SVH

// ========================================
// register map (byte offsets; word index is offset / 4)
`define DSSW_ADDR_STATUS 8'h00
`define DSSW_ADDR_COMMAND 8'h04
`define DSSW_ADDR_CONFIG 8'h08
`define DSSW_ADDR_TIMEOUT 8'h0C
`define DSSW_ADDR_FAULTS 8'h10

// ========================================
// status word bit positions
`define DSSW_BIT_RTSO 0
`define DSSW_BIT_SWON 1
`define DSSW_BIT_OPEN 2
`define DSSW_BIT_FAULT 3
`define DSSW_BIT_VOLT 4
`define DSSW_BIT_QSTOP 5
`define DSSW_BIT_SOD 6
`define DSSW_BIT_WARN 7

// ========================================
// command word bit positions
`define DSSW_CMD_SWON 0
`define DSSW_CMD_ENV 1
`define DSSW_CMD_QS 2
`define DSSW_CMD_ENOP 3
`define DSSW_CMD_FRST 7

// ========================================
// reset values and timing
`define DSSW_CMD_RESET 16'h0000
`define DSSW_CFG_RESET 16'h0000
`define DSSW_TIMEOUT_RESET 16'h0064
`define DSSW_TIMEOUT_UNIT_US 100
`define DSSW_CLK_NS 100
`define DSSW_TICK_CYCLES ((`DSSW_TIMEOUT_UNIT_US * 1000) / `DSSW_CLK_NS)
`define DSSW_STOP_CYCLES 16

`endif

// ===== verilog/dssw_pkg.sv
// types for the drive state status word block
`default_nettype none
package dssw_pkg;
	// drive operating states
	typedef enum logic [2:0] {
		DSSW_NOT_READY,
		DSSW_SW_DISABLED,
		DSSW_READY,
		DSSW_SWITCHED_ON,
		DSSW_OP_ENABLED,
		DSSW_QUICK_STOP,
		DSSW_FAULT_REACT,
		DSSW_FAULT
	} dssw_state_t;
endpackage : dssw_pkg
`default_nettype wire

// ===== verilog/dssw_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module dssw_sync (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic asyncIn,
	output logic syncOut
);
	logic stage1;

	// ========================================
	// sync chain; stage1 feeds only syncOut
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stage1 <= 1'b0;
			syncOut <= 1'b0;
		end else begin
			stage1 <= asyncIn;
			syncOut <= stage1;
		end
	end
endmodule : dssw_sync
`default_nettype wire

// ===== verilog/dssw_tick.sv
// divider giving a one-cycle enable pulse per timeout unit
`timescale 1ns/1ps
`default_nettype none
`include "dssw_defines.svh"
module dssw_tick (
	input wire logic clk_sys,
	input wire logic sys_rst,
	output logic tick
);
	localparam int unsigned CYC = `DSSW_TICK_CYCLES;
	logic [15:0] divCnt;

	// ========================================
	// free-running divider
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			divCnt <= 16'h0000;
			tick <= 1'b0;
		end else if (divCnt == 16'(CYC - 1)) begin
			divCnt <= 16'h0000;
			tick <= 1'b1;
		end else begin
			divCnt <= divCnt + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule : dssw_tick
`default_nettype wire

// ===== verilog/dssw_core.sv
// drive operating state machine, status word and power-up sequencing
// ========================================
`timescale 1ns/1ps
`default_nettype none
`include "dssw_defines.svh"
module dssw_core
	import dssw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	input wire logic powerStagePresent,
	input wire logic driveFaultIn,
	input wire logic driveWarnIn,
	input wire logic remoteIn,
	output logic mainsContactorClose,
	output logic [15:0] drive_status_word,
	output logic inputContactorError
);
	dssw_state_t state;
	dssw_state_t next_state;
	logic [15:0] cmdWord;
	logic [15:0] prevCmd;
	logic [15:0] cfgWord;
	logic [15:0] timeoutUnits;
	logic [15:0] waitCnt;
	logic [7:0] stopCnt;
	logic [7:0] reactCnt;
	logic faultFromQs;
	logic faultPend;
	logic supplySync;
	logic faultSync;
	logic tick;
	logic contactorMode;
	logic cmdWrite;
	logic fresetEdge;
	logic cShutdown, cSwitchOn, cEnableOp, cDisableV, cQuickStop;
	logic [15:0] next_status;

	// ========================================
	// pin synchronisers and timeout tick
	dssw_sync uSyncSupply (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.asyncIn(powerStagePresent),
		.syncOut(supplySync)
	);
	dssw_sync uSyncFault (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.asyncIn(driveFaultIn),
		.syncOut(faultSync)
	);
	dssw_tick uTick (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.tick(tick)
	);

	// ========================================
	// register writes
	assign cmdWrite = regWr && (regAddr == `DSSW_ADDR_COMMAND);
	assign contactorMode = cfgWord[0];

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cmdWord <= `DSSW_CMD_RESET;
			cfgWord <= `DSSW_CFG_RESET;
			timeoutUnits <= `DSSW_TIMEOUT_RESET;
		end else if (regWr) begin
			if (regAddr == `DSSW_ADDR_COMMAND) cmdWord <= regWdata;
			if (regAddr == `DSSW_ADDR_CONFIG) cfgWord <= regWdata;
			if (regAddr == `DSSW_ADDR_TIMEOUT) timeoutUnits <= regWdata;
		end
	end

	// previous command, for the fault-reset rising edge
	always_ff @(posedge clk_sys) begin
		if (sys_rst) prevCmd <= `DSSW_CMD_RESET;
		else if (cmdWrite) prevCmd <= cmdWord;
	end

	// ========================================
	// command decode; commands act on the cycle after a command write, except a stored enable operation in switched on
	logic cmdFresh;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) cmdFresh <= 1'b0;
		else cmdFresh <= cmdWrite;
	end
	assign cDisableV = !cmdWord[`DSSW_CMD_ENV];
	assign cQuickStop = cmdWord[`DSSW_CMD_ENV] && !cmdWord[`DSSW_CMD_QS];
	assign cShutdown = cmdWord[`DSSW_CMD_ENV] && cmdWord[`DSSW_CMD_QS] && !cmdWord[`DSSW_CMD_SWON];
	assign cSwitchOn = cmdWord[`DSSW_CMD_ENV] && cmdWord[`DSSW_CMD_QS] && cmdWord[`DSSW_CMD_SWON];
	assign cEnableOp = cSwitchOn && cmdWord[`DSSW_CMD_ENOP];
	assign fresetEdge = cmdFresh && cmdWord[`DSSW_CMD_FRST] && !prevCmd[`DSSW_CMD_FRST];

	// ========================================
	// state transitions
	always_comb begin
		next_state = state;
		unique case (state)
			DSSW_NOT_READY: next_state = DSSW_SW_DISABLED;
			DSSW_SW_DISABLED: begin
				if (cmdFresh && cShutdown) next_state = DSSW_READY;
			end
			DSSW_READY: begin
				if (cmdFresh && cDisableV) next_state = DSSW_SW_DISABLED;
				else if (cmdFresh && cSwitchOn) next_state = DSSW_SWITCHED_ON;
			end
			DSSW_SWITCHED_ON: begin
				if (cmdFresh && cDisableV) next_state = DSSW_SW_DISABLED;
				else if (cmdFresh && cShutdown) next_state = DSSW_READY;
				else if (cEnableOp && supplySync) next_state = DSSW_OP_ENABLED;
			end
			DSSW_OP_ENABLED: begin
				if (cmdFresh && cDisableV) next_state = DSSW_SW_DISABLED;
				else if (cmdFresh && cQuickStop) next_state = DSSW_QUICK_STOP;
				else if (cmdFresh && cShutdown) next_state = DSSW_READY;
				else if (cmdFresh && cSwitchOn && !cEnableOp) next_state = DSSW_SWITCHED_ON;
			end
			DSSW_QUICK_STOP: begin
				if (stopCnt == 8'(`DSSW_STOP_CYCLES) || (cmdFresh && cDisableV))
					next_state = DSSW_SW_DISABLED;
			end
			DSSW_FAULT_REACT: begin
				if (reactCnt == 8'(`DSSW_STOP_CYCLES)) next_state = DSSW_FAULT;
			end
			DSSW_FAULT: begin
				if (fresetEdge && !faultSync) next_state = DSSW_SW_DISABLED;
			end
		endcase
		// faults preempt every state except an existing fault
		if (faultPend && state != DSSW_FAULT_REACT && state != DSSW_FAULT)
			next_state = DSSW_FAULT_REACT;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) state <= DSSW_NOT_READY;
		else state <= next_state;
	end

	// ========================================
	// stop and fault-reaction timers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stopCnt <= 8'h00;
			reactCnt <= 8'h00;
		end else begin
			stopCnt <= (state == DSSW_QUICK_STOP) ? stopCnt + 8'h01 : 8'h00;
			reactCnt <= (state == DSSW_FAULT_REACT) ? reactCnt + 8'h01 : 8'h00;
		end
	end

	// remember whether the fault came out of quick stop
	always_ff @(posedge clk_sys) begin
		if (sys_rst) faultFromQs <= 1'b0;
		else if (next_state == DSSW_FAULT_REACT && state != DSSW_FAULT_REACT)
			faultFromQs <= (state == DSSW_QUICK_STOP);
		else if (next_state == DSSW_SW_DISABLED) faultFromQs <= 1'b0;
	end

	// ========================================
	// supply timeout in switched on
	// counter saturates so a long wait cannot wrap back under the limit
	always_ff @(posedge clk_sys) begin
		if (sys_rst) waitCnt <= 16'h0000;
		else if (state != DSSW_SWITCHED_ON || supplySync) waitCnt <= 16'h0000;
		else if (tick && waitCnt != 16'hFFFF) waitCnt <= waitCnt + 16'h0001;
	end

	// error is sticky until fault reset; set wins over clear
	always_ff @(posedge clk_sys) begin
		if (sys_rst) inputContactorError <= 1'b0;
		else if (state == DSSW_SWITCHED_ON && !supplySync && waitCnt >= timeoutUnits)
			inputContactorError <= 1'b1;
		else if (fresetEdge) inputContactorError <= 1'b0;
	end

	assign faultPend = faultSync || (inputContactorError && state != DSSW_FAULT);

	// ========================================
	// mains contactor: open until switch-on is commanded
	always_ff @(posedge clk_sys) begin
		if (sys_rst) mainsContactorClose <= 1'b0;
		else if (!contactorMode) mainsContactorClose <= 1'b0;
		else if (state == DSSW_READY && cmdFresh && cSwitchOn)
			mainsContactorClose <= 1'b1;
		else if (next_state == DSSW_SW_DISABLED || next_state == DSSW_READY
			|| next_state == DSSW_FAULT || next_state == DSSW_NOT_READY)
			mainsContactorClose <= 1'b0;
	end

	// ========================================
	// status word
	always_comb begin
		next_status = 16'h0000;
		next_status[`DSSW_BIT_VOLT] = supplySync;
		next_status[`DSSW_BIT_WARN] = driveWarnIn;
		next_status[9] = remoteIn;
		next_status[`DSSW_BIT_QSTOP] = 1'b1;
		unique case (state)
			DSSW_NOT_READY: next_status[`DSSW_BIT_QSTOP] = 1'b0;
			DSSW_SW_DISABLED: begin
				next_status[`DSSW_BIT_SOD] = 1'b1;
				next_status[`DSSW_BIT_QSTOP] = 1'b0;
			end
			DSSW_READY: next_status[`DSSW_BIT_RTSO] = 1'b1;
			DSSW_SWITCHED_ON: next_status[1:0] = 2'b11;
			DSSW_OP_ENABLED: next_status[2:0] = 3'b111;
			DSSW_QUICK_STOP: begin
				next_status[2:0] = 3'b111;
				next_status[`DSSW_BIT_QSTOP] = 1'b0;
			end
			DSSW_FAULT_REACT: begin
				next_status[3:0] = 4'b1111;
				next_status[`DSSW_BIT_QSTOP] = !faultFromQs;
			end
			DSSW_FAULT: begin
				next_status[`DSSW_BIT_FAULT] = 1'b1;
				next_status[`DSSW_BIT_QSTOP] = faultFromQs;
			end
		endcase
	end

	// no wait on the supply bit: registered once after the synchroniser
	always_ff @(posedge clk_sys) begin
		if (sys_rst) drive_status_word <= 16'h0000;
		else drive_status_word <= next_status;
	end

	// ========================================
	// register reads, one cycle later; unmapped reads return zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) regRdata <= 16'h0000;
		else if (regRd) begin
			unique case (regAddr)
				`DSSW_ADDR_STATUS: regRdata <= drive_status_word;
				`DSSW_ADDR_COMMAND: regRdata <= cmdWord;
				`DSSW_ADDR_CONFIG: regRdata <= cfgWord;
				`DSSW_ADDR_TIMEOUT: regRdata <= timeoutUnits;
				`DSSW_ADDR_FAULTS: regRdata <= {13'h0000, faultFromQs, faultSync, inputContactorError};
				default: regRdata <= 16'h0000;
			endcase
		end else regRdata <= 16'h0000;
	end

	// ========================================
	// assertions
	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
		drive_status_word[8] == 1'b0 && drive_status_word[13:12] == 2'b00)
		else $error("reserved status bits not zero");
	a_masked_ready: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_READY) |=> (drive_status_word & 16'h006F) == 16'h0021)
		else $error("ready masked value wrong");
	a_masked_swon: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_SWITCHED_ON) |=> (drive_status_word & 16'h006F) == 16'h0023)
		else $error("switched on masked value wrong");
	a_masked_openable: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_OP_ENABLED) |=> (drive_status_word & 16'h006F) == 16'h0027)
		else $error("operation enabled masked value wrong");
	a_masked_qstop: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_QUICK_STOP) |=> (drive_status_word & 16'h006F) == 16'h0007)
		else $error("quick stop masked value wrong");
	a_fault_value: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_FAULT) |=> ((drive_status_word & 16'h006F) == 16'h0008
		|| (drive_status_word & 16'h006F) == 16'h0028))
		else $error("fault masked value wrong");
	a_ready_voltage: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_READY && $stable(state)) |=> drive_status_word[7:0] ==
		(8'h21 | {3'b000, $past(supplySync), 4'h0} | {$past(driveWarnIn), 7'h00}))
		else $error("ready status byte wrong");
	a_voltage_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
		1'b1 |=> drive_status_word[4] == $past(supplySync))
		else $error("voltage bit lags supply");
	a_contactor_mode: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!contactorMode |=> !mainsContactorClose)
		else $error("contactor closed outside contactor mode");
	a_contactor_close: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(contactorMode && state == DSSW_READY && cmdFresh && cSwitchOn && !faultPend)
		|=> mainsContactorClose)
		else $error("switch on did not close contactor");
	a_direct_enable: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_READY && cmdFresh && cEnableOp && supplySync && !faultPend)
		|=> state == DSSW_SWITCHED_ON ##1 state == DSSW_OP_ENABLED)
		else $error("enable operation not taken from ready");
	a_timeout_err: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_SWITCHED_ON && !supplySync && waitCnt >= timeoutUnits)
		|=> inputContactorError)
		else $error("contactor error not raised");
	a_shutdown_nosup: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_SW_DISABLED && cmdFresh && cShutdown && !faultPend)
		|=> state == DSSW_READY)
		else $error("shutdown did not reach ready");
	a_swdis_value: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_SW_DISABLED) |=> (drive_status_word & 16'h006F) == 16'h0040)
		else $error("switch on disabled masked value wrong");
	a_not_ready_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_NOT_READY) |=> (drive_status_word & 16'h004F) == 16'h0000)
		else $error("not ready status bits not zero");
	a_react_bits: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_FAULT_REACT) |=> drive_status_word[3:0] == 4'b1111
		&& drive_status_word[6] == 1'b0)
		else $error("fault reaction status bits wrong");
	a_swon_direct: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_SWITCHED_ON && !cmdFresh && cEnableOp && supplySync && !faultPend)
		|=> state == DSSW_OP_ENABLED)
		else $error("stored enable operation not taken");
	a_error_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(inputContactorError && !fresetEdge) |=> inputContactorError)
		else $error("contactor error cleared without fault reset");
	a_contactor_open: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == DSSW_SW_DISABLED) |=> !mainsContactorClose)
		else $error("contactor closed in switch on disabled");

	// main paths the scenarios should reach
	c_reach_op: cover property (@(posedge clk_sys) state == DSSW_OP_ENABLED);
	c_ready_supply: cover property (@(posedge clk_sys) state == DSSW_READY && supplySync);
	c_qs_fault: cover property (@(posedge clk_sys) state == DSSW_FAULT && faultFromQs);
	c_timeout: cover property (@(posedge clk_sys) $rose(inputContactorError));
	c_contactor: cover property (@(posedge clk_sys) $rose(mainsContactorClose));
endmodule : dssw_core
`default_nettype wire

// ===== tb/dssw_plc_model.sv
// fieldbus master and power stage supply model facing the status word block
`timescale 1ns/1ps
`default_nettype none
`include "dssw_defines.svh"
module dssw_plc_model (
	input wire logic clk_sys,
	output logic [7:0] regAddr,
	output logic [15:0] regWdata,
	output logic regWr,
	output logic regRd,
	input wire logic [15:0] regRdata,
	input wire logic mainsContactorClose,
	input wire logic contactorMode,
	input wire logic supplyOn,
	output logic powerStagePresent
);
	// ========================================
	// supply
	// bus idle from time zero; supply first driven at the first clock edge
	initial begin
		regAddr = 8'h00;
		regWdata = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
	end

	// with the drive owning the contactor the supply only follows its closing
	always @(posedge clk_sys) begin
		powerStagePresent <= contactorMode ? mainsContactorClose : supplyOn;
	end

	// ========================================
	// bus cycles
	// one-cycle write strobe; the slave never stalls
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe, so take them mid-cycle
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(negedge clk_sys);
		d = regRdata;
	endtask : rd

	// poll the masked status until the wanted state shows, bounded so a stuck drive ends it
	task automatic wait_state(input logic [15:0] want, output logic [15:0] got);
		got = 16'h0000;
		for (int i = 0; i < 64 && got !== want; i++) begin
			rd(`DSSW_ADDR_STATUS, got);
			got = got & 16'h006F;
		end
	endtask : wait_state
endmodule : dssw_plc_model
`default_nettype wire

// ===== tb/drive_state_status_word_tb_top.sv
// self-checking bench for the drive state status word block
`timescale 1ns/1ps
`default_nettype none
`include "dssw_defines.svh"
module drive_state_status_word_tb_top;
	logic clk_sys;
	logic sys_rst;
	logic [7:0] regAddr;
	logic [15:0] regWdata;
	logic regWr;
	logic regRd;
	logic [15:0] regRdata;
	logic powerStagePresent;
	logic driveFaultIn;
	logic driveWarnIn;
	logic remoteIn;
	logic mainsContactorClose;
	logic [15:0] statusWord;
	logic inputContactorError;
	logic contactorMode;
	logic supplyOn;
	logic [15:0] rdData;
	int n_mismatch = 0;
	int checks = 0;

	// ========================================
	// instances
	dssw_core i_dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.powerStagePresent(powerStagePresent), .driveFaultIn(driveFaultIn),
		.driveWarnIn(driveWarnIn), .remoteIn(remoteIn),
		.mainsContactorClose(mainsContactorClose), .drive_status_word(statusWord),
		.inputContactorError(inputContactorError)
	);
	dssw_plc_model i_plc (
		.clk_sys(clk_sys), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .mainsContactorClose(mainsContactorClose),
		.contactorMode(contactorMode), .supplyOn(supplyOn),
		.powerStagePresent(powerStagePresent)
	);

	// ========================================
	// helpers
	// 10 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp16

	task automatic stop_test;
		if (n_mismatch == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	// each scenario starts from a fresh reset so states do not leak across
	task automatic do_reset;
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		contactorMode <= 1'b0;
		supplyOn <= 1'b0;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
	endtask : do_reset

	task automatic go(input logic [15:0] cmd);
		i_plc.wr(`DSSW_ADDR_COMMAND, cmd);
	endtask : go

	task automatic state(input logic [15:0] want);
		logic [15:0] got;
		i_plc.wait_state(want, got);
		cmp16(got, want);
	endtask : state

	// ========================================
	// scenarios
	// reset values, read-only status, unmapped place
	task automatic t_reset;
		do_reset();
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		cmp16(statusWord & 16'h006F, 16'h0040);
		i_plc.rd(`DSSW_ADDR_CONFIG, rdData);
		cmp16(rdData, `DSSW_CFG_RESET);
		i_plc.rd(`DSSW_ADDR_TIMEOUT, rdData);
		cmp16(rdData, `DSSW_TIMEOUT_RESET);
		i_plc.rd(8'h3C, rdData);
		cmp16(rdData, 16'h0000);
		i_plc.wr(`DSSW_ADDR_STATUS, 16'hFFFF);
		state(16'h0040);
	endtask : t_reset

	// shared supply: shutdown, enable directly, quick stop, fault after quick stop
	task automatic t_shared;
		do_reset();
		supplyOn <= 1'b1;
		remoteIn <= 1'b1;
		driveWarnIn <= 1'b1;
		go(16'h0006);
		state(16'h0021);
		@(negedge clk_sys);
		cmp16(statusWord, 16'h02B1);
		go(16'h000F);
		state(16'h0027);
		go(16'h0007);
		state(16'h0023);
		go(16'h000F);
		state(16'h0027);
		go(16'h0002);
		state(16'h0007);
		@(posedge clk_sys);
		driveFaultIn <= 1'b1;
		state(16'h0028);
		@(posedge clk_sys);
		driveFaultIn <= 1'b0;
		remoteIn <= 1'b0;
		driveWarnIn <= 1'b0;
		go(16'h0080);
		state(16'h0040);
	endtask : t_shared

	// separate control stage: ready without supply, then supply arrives
	task automatic t_separate;
		do_reset();
		go(16'h0006);
		state(16'h0021);
		@(negedge clk_sys);
		cmp16(statusWord, 16'h0021);
		@(posedge clk_sys);
		supplyOn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		cmp16(statusWord, 16'h0021);
		@(negedge clk_sys);
		cmp16(statusWord, 16'h0031);
		go(16'h0007);
		state(16'h0023);
		go(16'h000F);
		state(16'h0027);
		go(16'h0002);
		state(16'h0007);
		state(16'h0040);
		go(16'h0006);
		state(16'h0021);
		go(16'h0000);
		state(16'h0040);
	endtask : t_separate

	// supply never comes in switched on: contactor error, fault reaction, fault, reset
	task automatic t_timeout;
		do_reset();
		i_plc.wr(`DSSW_ADDR_TIMEOUT, 16'h0001);
		go(16'h0006);
		state(16'h0021);
		go(16'h0007);
		state(16'h0023);
		for (int i = 0; i < 2500 && inputContactorError !== 1'b1; i++) @(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		cmp16({15'h0000, inputContactorError}, 16'h0001);
		cmp16(statusWord & 16'h004F, 16'h000F);
		state(16'h0008);
		i_plc.rd(`DSSW_ADDR_FAULTS, rdData);
		cmp16(rdData & 16'h0001, 16'h0001);
		go(16'h0080);
		state(16'h0040);
		cmp16({15'h0000, inputContactorError}, 16'h0000);
	endtask : t_timeout

	// drive-controlled contactor stays open until switch on
	task automatic t_contactor;
		do_reset();
		contactorMode <= 1'b1;
		supplyOn <= 1'b1;
		i_plc.wr(`DSSW_ADDR_CONFIG, 16'h0001);
		go(16'h0006);
		state(16'h0021);
		@(negedge clk_sys);
		cmp16({15'h0000, mainsContactorClose}, 16'h0000);
		cmp16(statusWord & 16'h0010, 16'h0000);
		go(16'h0007);
		state(16'h0023);
		// supply needs the model's flop, two sync flops and the status register
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		cmp16({15'h0000, mainsContactorClose}, 16'h0001);
		cmp16(statusWord & 16'h0010, 16'h0010);
		go(16'h0006);
		state(16'h0021);
		@(negedge clk_sys);
		cmp16({15'h0000, mainsContactorClose}, 16'h0000);
	endtask : t_contactor

	// ========================================
	// main sequence and watchdog
	initial begin
		sys_rst = 1'b1;
		driveFaultIn = 1'b0;
		driveWarnIn = 1'b0;
		remoteIn = 1'b0;
		contactorMode = 1'b0;
		supplyOn = 1'b0;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_reset();
		t_shared();
		t_separate();
		t_timeout();
		t_contactor();
		stop_test();
	end

	// the scenarios need well under ten thousand cycles
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_mismatch++;
		$display("MISMATCH %0t watchdog expired", $time);
		stop_test();
	end
endmodule : drive_state_status_word_tb_top
`default_nettype wire
